/* File: hdl/ingress_rate_meter_config.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - config bits 2:1 pick port+priority, port, or priority metering; reset 00.
// - config bit 0 enables metering, coloring and dropping; reset zero.
// - each command register write launches one indirect table access.
// - command bit 7 is one for table read, zero for write; reset zero.
// - type 01 rate entries, 10 committed burst, 11 excess burst, 00 reserved.
// - five-bit index picks one of 24 committed rate entries; reset zero.
// - port+priority mode: port groups of eight, priority 0 lowest entry.
// - port only mode uses entries 0, 1, 2 for ports 0, 1, 2.
// - priority only mode uses the entry equal to the priority, up to 23.
// - table entries are 16 bits, reachable only through the command register.
// - excess burst entry in bytes, reset 0600h, excess overflow dropped.
// - excess buckets start at default; lower value applies after draining.
// - committed burst entry in bytes, reset 0600h, overflow randomly dropped.
// - committed buckets start at default; lower value applies after draining.
// - byte time equals entry plus one times 20 ns; entries reset 0014h.
// - read-only pending flag is set during an access, self clearing.
// - write data bits 15:0 hold the value to store; reset zero.
// - read data bits 15:0 return the entry of the last indirect read.
module ingress_rate_meter_config #(
	parameter int unsigned ACCESS_CYCLES = ingress_rate_pkg::ACCESS_CYCLES
) (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	// management register port
	input  wire logic [15:0] reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [31:0] reg_wdata_i,
	output logic      [31:0] reg_rdata_o,
	output logic             reg_rvalid_o,
	// metering datapath controls
	output logic             meter_enable_o,
	output logic      [1:0]  rate_mode_o,
	output logic      [15:0] committed_burst_o,
	output logic      [15:0] excess_burst_o,
	output logic             bucket_init_o,
	// committed rate lookup
	input  wire logic        lookup_valid_i,
	input  wire logic [1:0]  lookup_port_i,
	input  wire logic [4:0]  lookup_prio_i,
	output logic             lookup_valid_o,
	output logic      [4:0]  lookup_index_o,
	output logic      [20:0] byte_time_ns_o
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_BUSY = 2'h1,
		ST_DONE = 2'h3
	} access_state_type;

	localparam logic [3:0] WAIT_LAST = 4'(ACCESS_CYCLES - 1);

	logic [1:0]       rst_sync_q;
	logic             rst_n;
	access_state_type state_q;
	logic [3:0]       wait_q;
	logic             pending_q;
	logic [7:0]       command_q;
	logic [15:0]      write_data_q;
	logic [15:0]      read_data_q;
	logic             init_done_q;
	logic             cmd_wr;
	logic             cfg_wr;
	logic             tbl_wr;
	logic             cmd_dir;
	logic [1:0]       cmd_target;
	logic [4:0]       cmd_index;
	logic [15:0]      tbl_rdata;
	logic [15:0]      tbl_committed;
	logic [15:0]      tbl_excess;
	logic [15:0]      tbl_rate;
	logic [4:0]       index_d;
	logic [31:0]      rdata_d;

	////////////////////////////////////////////////////////////////////////////////
	// reset release
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	assign rst_n = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////////////////
	// register decode
	assign cfg_wr     = reg_wr_i && reg_addr_i == ingress_rate_pkg::CONFIG_IDX;
	assign cmd_wr     = reg_wr_i && reg_addr_i == ingress_rate_pkg::COMMAND_IDX;
	assign cmd_dir    = command_q[ingress_rate_pkg::CMD_DIR_BIT];
	assign cmd_target = command_q[ingress_rate_pkg::CMD_TYPE_MSB:ingress_rate_pkg::CMD_TYPE_LSB];
	assign cmd_index  = command_q[ingress_rate_pkg::CMD_INDEX_MSB:ingress_rate_pkg::CMD_INDEX_LSB];

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meter_enable_o <= ingress_rate_pkg::ENABLE_RESET;
			rate_mode_o    <= ingress_rate_pkg::MODE_RESET;
		end
		else if (cfg_wr)
		begin
			meter_enable_o <= reg_wdata_i[ingress_rate_pkg::CFG_ENABLE_BIT];
			rate_mode_o    <= reg_wdata_i[ingress_rate_pkg::CFG_MODE_MSB:ingress_rate_pkg::CFG_MODE_LSB];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			command_q <= ingress_rate_pkg::COMMAND_RESET;
		else if (cmd_wr)
			command_q <= reg_wdata_i[ingress_rate_pkg::CMD_W-1:0];
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			write_data_q <= ingress_rate_pkg::WRITE_DATA_RESET;
		else if (reg_wr_i && reg_addr_i == ingress_rate_pkg::WRITE_DATA_IDX)
			write_data_q <= reg_wdata_i[15:0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// indirect access sequencer
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= ST_IDLE;
			wait_q  <= 4'h0;
		end
		else if (cmd_wr)
		begin
			state_q <= ST_BUSY;
			wait_q  <= WAIT_LAST;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
					state_q <= ST_IDLE;
				ST_BUSY:
				begin
					if (wait_q == 4'h0)
						state_q <= ST_DONE;
					else
						wait_q <= wait_q - 4'h1;
				end
				ST_DONE:
					state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// a new command in the completing cycle keeps the flag set
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			pending_q <= 1'b0;
		else if (cmd_wr)
			pending_q <= 1'b1;
		else if (state_q == ST_DONE)
			pending_q <= 1'b0;
	end

	assign tbl_wr = state_q == ST_DONE && !cmd_dir;

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			read_data_q <= ingress_rate_pkg::READ_DATA_RESET;
		else if (state_q == ST_DONE && cmd_dir)
			read_data_q <= tbl_rdata;
	end

	ingress_rate_table #(
		.ENTRIES (ingress_rate_pkg::RATE_ENTRIES)
	) u_table (
		.clk_i             (sys_clk_i),
		.rst_n_i           (rst_n),
		.wr_en_i           (tbl_wr),
		.target_i          (cmd_target),
		.index_i           (cmd_index),
		.wdata_i           (write_data_q),
		.rdata_o           (tbl_rdata),
		.lookup_index_i    (index_d),
		.lookup_value_o    (tbl_rate),
		.committed_burst_o (tbl_committed),
		.excess_burst_o    (tbl_excess)
	);

	////////////////////////////////////////////////////////////////////////////////
	// register read port; the table itself is not mapped
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		case (reg_addr_i)
			ingress_rate_pkg::CONFIG_IDX:
				rdata_d = {29'h0, rate_mode_o, meter_enable_o};
			ingress_rate_pkg::COMMAND_IDX:
				rdata_d = {24'h0, command_q};
			ingress_rate_pkg::STATUS_IDX:
				rdata_d = {31'h0, pending_q};
			ingress_rate_pkg::WRITE_DATA_IDX:
				rdata_d = {16'h0, write_data_q};
			ingress_rate_pkg::READ_DATA_IDX:
				rdata_d = {16'h0, read_data_q};
			default:
				rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata_o  <= 32'h0000_0000;
			reg_rvalid_o <= 1'b0;
		end
		else
		begin
			reg_rdata_o  <= reg_rd_i ? rdata_d : 32'h0000_0000;
			reg_rvalid_o <= reg_rd_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// burst sizes and bucket preset
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			committed_burst_o <= ingress_rate_pkg::COMMITTED_RESET;
			excess_burst_o    <= ingress_rate_pkg::EXCESS_RESET;
		end
		else
		begin
			committed_burst_o <= tbl_committed;
			excess_burst_o    <= tbl_excess;
		end
	end

	// buckets fill to the default once; later limits only cap, never refill
	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			init_done_q   <= 1'b0;
			bucket_init_o <= 1'b0;
		end
		else
		begin
			init_done_q   <= 1'b1;
			bucket_init_o <= !init_done_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// committed rate lookup
	always_comb
	begin
		index_d = 5'h00;
		case (rate_mode_o)
			ingress_rate_pkg::MODE_PORT_PRIO:
				index_d = {lookup_port_i, lookup_prio_i[ingress_rate_pkg::PRIO_BITS-1:0]};
			ingress_rate_pkg::MODE_PORT:
				index_d = {3'h0, lookup_port_i};
			ingress_rate_pkg::MODE_PRIO:
				index_d = lookup_prio_i;
			default:
				index_d = 5'h00;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lookup_valid_o <= 1'b0;
			lookup_index_o <= 5'h00;
			byte_time_ns_o <= 21'h000000;
		end
		else
		begin
			lookup_valid_o <= lookup_valid_i && meter_enable_o;
			if (lookup_valid_i)
			begin
				lookup_index_o <= index_d;
				byte_time_ns_o <= 21'(({5'h00, tbl_rate} + 21'h1)
					* 21'(ingress_rate_pkg::RATE_STEP_NS));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	property p_config_write;
		@(posedge sys_clk_i) disable iff (!rst_n)
		cfg_wr |=> rate_mode_o == $past(reg_wdata_i[2:1]) && meter_enable_o == $past(reg_wdata_i[0]);
	endproperty
	a_config_write: assert property (p_config_write) else $error("config not stored");

	property p_disabled_no_lookup;
		@(posedge sys_clk_i) disable iff (!rst_n)
		!meter_enable_o |=> !lookup_valid_o;
	endproperty
	a_disabled_no_lookup: assert property (p_disabled_no_lookup) else $error("metering while off");

	property p_launch;
		@(posedge sys_clk_i) disable iff (!rst_n)
		cmd_wr |=> pending_q && state_q == ST_BUSY;
	endproperty
	a_launch: assert property (p_launch) else $error("command did not launch");

	property p_pending_bound;
		@(posedge sys_clk_i) disable iff (!rst_n)
		cmd_wr ##1 !cmd_wr [*2] |-> ##[0:14] (state_q == ST_DONE);
	endproperty
	a_pending_bound: assert property (p_pending_bound) else $error("access never completes");

	property p_pending_clear;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(state_q == ST_DONE && !cmd_wr) |=> !pending_q && state_q == ST_IDLE;
	endproperty
	a_pending_clear: assert property (p_pending_clear) else $error("pending not cleared");

	property p_read_capture;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(state_q == ST_DONE && cmd_dir) |=> read_data_q == $past(tbl_rdata);
	endproperty
	a_read_capture: assert property (p_read_capture) else $error("read data not captured");

	property p_excess_write;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(state_q == ST_DONE && !cmd_dir && cmd_target == ingress_rate_pkg::TGT_EXCESS_BURST)
		|=> tbl_excess == $past(write_data_q) ##1 excess_burst_o == $past(write_data_q, 2);
	endproperty
	a_excess_write: assert property (p_excess_write) else $error("excess burst not written");

	property p_read_no_write;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(state_q == ST_DONE && cmd_dir) |=> $stable(tbl_committed) && $stable(tbl_excess);
	endproperty
	a_read_no_write: assert property (p_read_no_write) else $error("read changed table");

	property p_index_port_prio;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(lookup_valid_i && rate_mode_o == ingress_rate_pkg::MODE_PORT_PRIO)
		|=> lookup_index_o == 5'({$past(lookup_port_i), 3'h0} + {3'h0, $past(lookup_prio_i[1:0])}
			+ {2'h0, $past(lookup_prio_i[2]), 2'h0});
	endproperty
	a_index_port_prio: assert property (p_index_port_prio) else $error("bad port+prio index");

	property p_index_port;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(lookup_valid_i && rate_mode_o == ingress_rate_pkg::MODE_PORT)
		|=> lookup_index_o == {3'h0, $past(lookup_port_i)};
	endproperty
	a_index_port: assert property (p_index_port) else $error("bad port index");

	property p_index_prio;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(lookup_valid_i && rate_mode_o == ingress_rate_pkg::MODE_PRIO)
		|=> lookup_index_o == $past(lookup_prio_i);
	endproperty
	a_index_prio: assert property (p_index_prio) else $error("bad priority index");

	property p_byte_time;
		@(posedge sys_clk_i) disable iff (!rst_n)
		lookup_valid_i |=> byte_time_ns_o == 21'($past(tbl_rate) * 20 + 20);
	endproperty
	a_byte_time: assert property (p_byte_time) else $error("bad byte time");

	property p_unmapped;
		@(posedge sys_clk_i) disable iff (!rst_n)
		(reg_rd_i && (reg_addr_i < ingress_rate_pkg::CONFIG_IDX
			|| reg_addr_i > ingress_rate_pkg::READ_DATA_IDX))
		|=> reg_rvalid_o && reg_rdata_o == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule

/* File: hdl/ingress_rate_pkg.sv */
package ingress_rate_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register numbers on the management register port
	localparam logic [15:0] CONFIG_IDX     = 16'h184a;
	localparam logic [15:0] COMMAND_IDX    = 16'h184b;
	localparam logic [15:0] STATUS_IDX     = 16'h184c;
	localparam logic [15:0] WRITE_DATA_IDX = 16'h184d;
	localparam logic [15:0] READ_DATA_IDX  = 16'h184e;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int unsigned CFG_ENABLE_BIT  = 0;
	localparam int unsigned CFG_MODE_LSB    = 1;
	localparam int unsigned CFG_MODE_MSB    = 2;
	localparam int unsigned CMD_DIR_BIT     = 7;
	localparam int unsigned CMD_TYPE_MSB    = 6;
	localparam int unsigned CMD_TYPE_LSB    = 5;
	localparam int unsigned CMD_INDEX_MSB   = 4;
	localparam int unsigned CMD_INDEX_LSB   = 0;
	localparam int unsigned STS_PENDING_BIT = 0;
	localparam int unsigned CMD_W           = 8;

	////////////////////////////////////////////////////////////////////////////////
	// modes and table targets
	typedef enum logic [1:0] {
		MODE_PORT_PRIO = 2'h0,
		MODE_PORT      = 2'h1,
		MODE_PRIO      = 2'h2,
		MODE_RESERVED  = 2'h3
	} rate_mode_type;

	typedef enum logic [1:0] {
		TGT_RESERVED        = 2'h0,
		TGT_COMMITTED_RATE  = 2'h1,
		TGT_COMMITTED_BURST = 2'h2,
		TGT_EXCESS_BURST    = 2'h3
	} target_type;

	////////////////////////////////////////////////////////////////////////////////
	// sizes and reset values
	localparam int unsigned ENTRY_W          = 16;
	localparam int unsigned RATE_ENTRIES     = 24;
	localparam int unsigned INDEX_W          = 5;
	localparam int unsigned PRIO_BITS        = 3;
	localparam int unsigned BYTE_TIME_W      = 21;
	localparam logic [1:0]  MODE_RESET       = 2'h0;
	localparam logic        ENABLE_RESET     = 1'h0;
	localparam logic [7:0]  COMMAND_RESET    = 8'h00;
	localparam logic [15:0] WRITE_DATA_RESET = 16'h0000;
	localparam logic [15:0] READ_DATA_RESET  = 16'h0000;
	localparam logic [15:0] EXCESS_RESET     = 16'h0600;
	localparam logic [15:0] COMMITTED_RESET  = 16'h0600;
	localparam logic [15:0] RATE_RESET       = 16'h0014;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned RATE_STEP_NS  = 20;
	localparam int unsigned ACCESS_CYCLES = 2;

endpackage

/* File: hdl/ingress_rate_table.sv */
`timescale 1ns/1ns
module ingress_rate_table #(
	parameter int unsigned ENTRIES = ingress_rate_pkg::RATE_ENTRIES
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// indirect access
	input  wire logic        wr_en_i,
	input  wire logic [1:0]  target_i,
	input  wire logic [4:0]  index_i,
	input  wire logic [15:0] wdata_i,
	output logic      [15:0] rdata_o,
	// datapath side
	input  wire logic [4:0]  lookup_index_i,
	output logic      [15:0] lookup_value_o,
	output logic      [15:0] committed_burst_o,
	output logic      [15:0] excess_burst_o
);

	logic [15:0] rate_q [ENTRIES];

	////////////////////////////////////////////////////////////////////////////////
	// committed rate entries
	generate
		for (genvar i = 0; i < ENTRIES; i++)
		begin : g_entry
			always_ff @(posedge clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
					rate_q[i] <= ingress_rate_pkg::RATE_RESET;
				else if (wr_en_i && target_i == ingress_rate_pkg::TGT_COMMITTED_RATE
					&& index_i == 5'(i))
					rate_q[i] <= wdata_i;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// burst entries
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			committed_burst_o <= ingress_rate_pkg::COMMITTED_RESET;
		else if (wr_en_i && target_i == ingress_rate_pkg::TGT_COMMITTED_BURST)
			committed_burst_o <= wdata_i;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			excess_burst_o <= ingress_rate_pkg::EXCESS_RESET;
		else if (wr_en_i && target_i == ingress_rate_pkg::TGT_EXCESS_BURST)
			excess_burst_o <= wdata_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	// read ports; out of range indices read as zero
	always_comb
	begin
		rdata_o = 16'h0000;
		case (target_i)
			ingress_rate_pkg::TGT_COMMITTED_RATE:
				rdata_o = (index_i < ENTRIES) ? rate_q[index_i] : 16'h0000;
			ingress_rate_pkg::TGT_COMMITTED_BURST:
				rdata_o = committed_burst_o;
			ingress_rate_pkg::TGT_EXCESS_BURST:
				rdata_o = excess_burst_o;
			default:
				rdata_o = 16'h0000;
		endcase
	end

	assign lookup_value_o = (lookup_index_i < ENTRIES) ? rate_q[lookup_index_i] : 16'h0000;

endmodule

/* File: tb/tb_ingress_rate_meter_config.sv */
`timescale 1ns/1ns
module tb_ingress_rate_meter_config;
	logic        sys_clk_i      = 1'b0;
	logic        rst_n_i        = 1'b0;
	logic [15:0] reg_addr_i     = 16'h0000;
	logic        reg_wr_i       = 1'b0;
	logic        reg_rd_i       = 1'b0;
	logic [31:0] reg_wdata_i    = 32'h0;
	logic [31:0] reg_rdata_o;
	logic        reg_rvalid_o;
	logic        meter_enable_o;
	logic [1:0]  rate_mode_o;
	logic [15:0] committed_burst_o;
	logic [15:0] excess_burst_o;
	logic        bucket_init_o;
	logic        lookup_valid_i = 1'b0;
	logic [1:0]  lookup_port_i  = 2'h0;
	logic [4:0]  lookup_prio_i  = 5'h00;
	logic        lookup_valid_o;
	logic [4:0]  lookup_index_o;
	logic [20:0] byte_time_ns_o;
	int          n_errors       = 0;
	int          num_checks     = 0;
	int          n_init         = 0;
	int          seed           = 81;
	int          rate_m [24];
	int          cb_m;
	int          eb_m;
	logic [31:0] rv;
	logic [31:0] w;

	always #20 sys_clk_i = ~sys_clk_i;

	always @(posedge sys_clk_i)
		if (bucket_init_o === 1'b1)
			n_init++;

	ingress_rate_meter_config i_ingress_rate_meter_config (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
		.meter_enable_o(meter_enable_o), .rate_mode_o(rate_mode_o),
		.committed_burst_o(committed_burst_o), .excess_burst_o(excess_burst_o),
		.bucket_init_o(bucket_init_o), .lookup_valid_i(lookup_valid_i),
		.lookup_port_i(lookup_port_i), .lookup_prio_i(lookup_prio_i),
		.lookup_valid_o(lookup_valid_o), .lookup_index_o(lookup_index_o),
		.byte_time_ns_o(byte_time_ns_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("FAIL %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask

	task automatic model_reset;
		foreach (rate_m[i])
			rate_m[i] = 16'h0014;
		cb_m = 16'h0600;
		eb_m = 16'h0600;
	endtask

	function automatic logic [31:0] exp_val(input logic [1:0] tgt, input int idx);
		if (tgt == 2'h1)
			return (idx < 24) ? rate_m[idx] : 0;
		if (tgt == 2'h2)
			return cb_m;
		if (tgt == 2'h3)
			return eb_m;
		return 0;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// register port cycles
	task automatic reg_write(input logic [15:0] addr, input logic [31:0] data);
		@(posedge sys_clk_i);
		reg_addr_i <= addr;
		reg_wdata_i <= data;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic reg_read(input logic [15:0] addr, output logic [31:0] data);
		@(posedge sys_clk_i);
		reg_addr_i <= addr;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		check("reg_rvalid_o", 32'h1, {31'h0, reg_rvalid_o});
		data = reg_rdata_o;
	endtask

	task automatic wait_idle;
		logic [31:0] s;
		int          n;
		s = 32'h1;
		n = 0;
		while (s[0] !== 1'b0 && n < 50)
		begin
			reg_read(ingress_rate_pkg::STATUS_IDX, s);
			n++;
		end
		if (s[0] !== 1'b0)
		begin
			$display("FAIL pending expected 0 seen %b", s[0]);
			n_errors++;
			summarize();
		end
	endtask

	// indirect access: write data first on writes only, then command, then poll pending
	task automatic access(input logic rd, input logic [1:0] tgt, input logic [4:0] idx,
		input logic [15:0] wd, output logic [31:0] rdv);
		logic [31:0] s;
		if (!rd)
			reg_write(ingress_rate_pkg::WRITE_DATA_IDX, {16'h0, wd});
		reg_write(ingress_rate_pkg::COMMAND_IDX, {24'h0, rd, tgt, idx});
		reg_read(ingress_rate_pkg::STATUS_IDX, s);
		check("pending", 32'h1, s);
		wait_idle();
		rdv = 32'h0;
		if (rd)
			reg_read(ingress_rate_pkg::READ_DATA_IDX, rdv);
		else if (tgt == 2'h1 && idx < 24)
			rate_m[idx] = wd;
		else if (tgt == 2'h2)
			cb_m = wd;
		else if (tgt == 2'h3)
			eb_m = wd;
	endtask

	task automatic check_entry(input logic [1:0] tgt, input logic [4:0] idx);
		logic [31:0] r;
		access(1'b1, tgt, idx, 16'h0, r);
		check("table entry", exp_val(tgt, idx), r);
	endtask

	task automatic lookup(input logic [1:0] port, input logic [4:0] prio, input logic [1:0] mode,
		input logic en);
		int idx;
		idx = (mode == 2'h0) ? port * 8 + prio[2:0] : (mode == 2'h1) ? port :
			(mode == 2'h2) ? prio : 0;
		@(posedge sys_clk_i);
		lookup_valid_i <= 1'b1;
		lookup_port_i <= port;
		lookup_prio_i <= prio;
		@(posedge sys_clk_i);
		lookup_valid_i <= 1'b0;
		#1;
		check("lookup_index_o", idx, {27'h0, lookup_index_o});
		check("byte_time_ns_o", (exp_val(2'h1, idx) + 1) * 20, {11'h0, byte_time_ns_o});
		check("lookup_valid_o", {31'h0, en}, {31'h0, lookup_valid_o});
	endtask

	task automatic reset_check;
		reg_read(ingress_rate_pkg::CONFIG_IDX, rv);
		check("config", 32'h0, rv);
		reg_read(ingress_rate_pkg::COMMAND_IDX, rv);
		check("command", 32'h0, rv);
		reg_read(ingress_rate_pkg::WRITE_DATA_IDX, rv);
		check("write data", 32'h0, rv);
		check("committed_burst_o", 32'h0600, {16'h0, committed_burst_o});
		check("excess_burst_o", 32'h0600, {16'h0, excess_burst_o});
		for (int i = 0; i < 24; i++)
			check_entry(2'h1, 5'(i));
		check_entry(2'h2, 0);
		check_entry(2'h3, 0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		model_reset();
		repeat (16) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		reset_check();
		check("bucket init pulses", 32'h1, n_init);
		$display("test reset values done");

		for (int i = 0; i < 24; i++)
			access(1'b0, 2'h1, 5'(i), 16'($random(seed)), rv);
		access(1'b0, 2'h2, 5'h00, 16'($random(seed)), rv);
		// excess burst kept at or above the default so large packets still pass
		access(1'b0, 2'h3, 5'h00, 16'h0600 | 16'($random(seed)), rv);
		access(1'b0, 2'h1, 5'(24 + ($random(seed) & 7)), 16'($random(seed)), rv);
		access(1'b0, 2'h0, 5'd3, 16'($random(seed)), rv);
		for (int i = 0; i < 32; i++)
			check_entry(2'h1, 5'(i));
		check_entry(2'h2, 0);
		check_entry(2'h3, 9);
		check_entry(2'h0, 0);
		reg_read(ingress_rate_pkg::COMMAND_IDX, rv);
		check("command readback", 32'h0000_0080, rv);
		check("committed_burst_o", cb_m, {16'h0, committed_burst_o});
		check("excess_burst_o", eb_m, {16'h0, excess_burst_o});
		$display("test table access done");

		for (int m = 0; m < 4; m++)
			for (int e = 0; e < 2; e++)
			begin
				w = $random(seed);
				w[2:0] = {m[1:0], e[0]};
				reg_write(ingress_rate_pkg::CONFIG_IDX, w);
				reg_read(ingress_rate_pkg::CONFIG_IDX, rv);
				check("config readback", {29'h0, w[2:0]}, rv);
				check("rate_mode_o", m, {30'h0, rate_mode_o});
				check("meter_enable_o", e, {31'h0, meter_enable_o});
				for (int k = 0; k < 4; k++)
					lookup(2'($unsigned($random(seed)) % 3),
						5'($unsigned($random(seed)) % 24), m[1:0], e[0]);
			end
		$display("test modes and lookups done");

		reg_write(ingress_rate_pkg::STATUS_IDX, 32'h1);
		reg_read(ingress_rate_pkg::STATUS_IDX, rv);
		check("status write ignored", 32'h0, rv);
		reg_write(ingress_rate_pkg::READ_DATA_IDX, 32'hffff);
		reg_read(ingress_rate_pkg::READ_DATA_IDX, rv);
		check("read data write ignored", 32'h0, rv);
		reg_write(16'h1850, 32'h1234);
		reg_read(16'h1850, rv);
		check("unmapped read", 32'h0, rv);
		$display("test refusals done");

		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		model_reset();
		reset_check();
		check("bucket init pulses", 32'h2, n_init);
		$display("test second reset done");
		summarize();
	end
endmodule
